// ==== rtl/usbps_map.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef USBPS_MAP_SVH
`define USBPS_MAP_SVH

`define USBPS_LAST_PID_OFS     8'h2c
`define USBPS_LAST_EP_OFS      8'h30
`define USBPS_EP_MASK_OFS      8'h34
`define USBPS_OTG_MASK_OFS     8'h38
`define USBPS_PWR_SIG_OFS      8'h3c
`define USBPS_PHY_CTRL_OFS     8'h40
`define USBPS_IRQ_STAT_OFS     8'h44
`define USBPS_IRQ_CLR_OFS      8'h48
`define USBPS_IRQ_EN_OFS       8'h4c
`define USBPS_LINE_STAT_OFS    8'h50

`define USBPS_EP_VALID_BIT     4
`define USBPS_PULLDOWN_BIT     18
`define USBPS_SE0_WAKE_BIT     13
`define USBPS_K_WAKE_BIT       12
`define USBPS_FILT_LSB         8
`define USBPS_SUSP_SEL_BIT     7
`define USBPS_CONF_LSB         4
`define USBPS_PWR_SIG_MASK     32'h0000_01ff
`define USBPS_EP_MASK_MASK     32'h0000_ffff

`define USBPS_IRQ_PKT_BIT      0
`define USBPS_IRQ_WAKE_BIT     1
`define USBPS_IRQ_LINE_BIT     2
`define USBPS_IRQ_W            3

`define USBPS_RESET_VAL        32'h0000_0000
`define USBPS_MAX_FILT_LOG2    15

`endif

// ==== rtl/usbps_pkg.sv ====
// Types shared by the packet snoop and PHY control block
`default_nettype none
package usbps_pkg;
   typedef enum logic [1:0] {
      USBPS_LS_SE0 = 2'h0,
      USBPS_LS_J   = 2'h1,
      USBPS_LS_K   = 2'h2,
      USBPS_LS_SE1 = 2'h3
   } usbps_line_t;

   typedef enum logic [1:0] {
      USBPS_ST_RUN,
      USBPS_ST_SUSP,
      USBPS_ST_WAKE
   } usbps_state_t;
endpackage : usbps_pkg
`default_nettype wire

// ==== rtl/usbps_filt_if.sv ====
// Carrier between the top and its line-state filter
`timescale 1ns/10ps
`default_nettype none
interface usbps_filt_if;
   logic [1:0] raw;
   logic [3:0] log2_delay;
   logic [1:0] filt;
   logic       changed;
   modport top  (output raw, output log2_delay, input filt, input changed);
   modport filter (input raw, input log2_delay, output filt, output changed);
endinterface : usbps_filt_if
`default_nettype wire

// ==== rtl/usbps_linefilt.sv ====
// Line-state filter: a change passes after 2**n stable cycles
`timescale 1ns/10ps
`default_nettype none
`include "usbps_map.svh"
module usbps_linefilt
   import usbps_pkg::*;
(
   input  wire logic   mclk,   // Module clock
   input  wire logic   srst,   // Synchronous reset
   usbps_filt_if.filter fif    // Raw in, filtered out
);
   logic [1:0]  cand_ff;
   logic [15:0] cnt_ff;
   logic [1:0]  filt_ff;
   logic        chg_ff;
   logic [15:0] limit;

   assign limit = 16'h0001 << fif.log2_delay;

   // Restart timing whenever the raw level moves
   always_ff @(posedge mclk) begin
      if (srst) begin
         // Idle bus is J: resetting to it avoids a false change
         cand_ff <= 2'(USBPS_LS_J);
         cnt_ff  <= 16'h0000;
      end else if (fif.raw != cand_ff) begin
         cand_ff <= fif.raw;
         cnt_ff  <= 16'h0001;
      end else if (cnt_ff != 16'hffff) begin
         cnt_ff <= cnt_ff + 16'h0001;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         filt_ff <= 2'(USBPS_LS_J);
         chg_ff  <= 1'b0;
      end else if (cand_ff != filt_ff && cnt_ff >= limit) begin
         filt_ff <= cand_ff;
         chg_ff  <= 1'b1;
      end else begin
         chg_ff <= 1'b0;
      end
   end

   assign fif.filt    = filt_ff;
   assign fif.changed = chg_ff;
endmodule : usbps_linefilt
`default_nettype wire

// ==== rtl/usbps_top.sv ====
// Packet snoop and PHY control registers behind an AHB-Lite slave
`timescale 1ns/10ps
`default_nettype none
`include "usbps_map.svh"
module usbps_top
   import usbps_pkg::*;
(
   input  wire logic        mclk,               // 100 MHz module clock
   input  wire logic        srst,               // Sync reset, active high
   input  wire logic        hsel,               // AHB slave select
   input  wire logic [31:0] haddr,              // AHB address
   input  wire logic [1:0]  htrans,             // AHB transfer type
   input  wire logic        hwrite,             // AHB write
   input  wire logic [2:0]  hsize,              // AHB size
   input  wire logic [31:0] hwdata,             // AHB write data
   input  wire logic        hready,             // AHB bus ready
   output logic      [31:0] hrdata,             // AHB read data
   output logic             hreadyout,          // AHB slave ready
   output logic             hresp,              // AHB response, OKAY
   input  wire logic        rx_pkt_valid,       // Packet decoded strobe
   input  wire logic [3:0]  rx_pid,             // Decoded packet identifier
   input  wire logic        rx_ep_valid,        // Endpoint field is valid
   input  wire logic [3:0]  rx_ep,              // Decoded endpoint number
   output logic      [4:0]  rx_port_ep,         // Endpoint on receive port
   output logic             rx_port_valid,      // Receive port strobe
   input  wire logic [1:0]  phy_linestate,      // Raw PHY line state pins
   input  wire logic        suspend_req,        // Suspend entry request
   output logic             pulldown_port_a_en, // Pulldown enable, port a
   output logic             pulldown_port_b_en, // Pulldown enable, port b
   output logic      [2:0]  phy_config_pins,    // PHY configuration pins
   output logic             phy_suspend_n,      // PHY suspend, active low
   output logic             irq                 // Level interrupt
);
   localparam logic [3:0] FILT_MAX = 4'(`USBPS_MAX_FILT_LOG2);

   usbps_filt_if fif ();

   logic [1:0]  ls_meta_ff;
   logic [1:0]  ls_sync_ff;
   logic        susp_meta_ff;
   logic        susp_sync_ff;
   logic [3:0]  pid_ff;
   logic [3:0]  ep_ff;
   logic        ep_valid_ff;
   logic [15:0] ep_mask_ff;
   logic [31:0] otg_mask_ff;
   logic [8:0]  pwr_sig_ff;
   logic        pd_dis_ff;
   logic        se0_wake_ff;
   logic        k_wake_ff;
   logic [3:0]  filt_ff;
   logic        susp_sel_ff;
   logic [2:0]  conf_ff;
   logic [`USBPS_IRQ_W-1:0] irq_stat_ff;
   logic [`USBPS_IRQ_W-1:0] irq_en_ff;
   logic [`USBPS_IRQ_W-1:0] irq_evt;
   usbps_state_t            st_ff;
   logic        wake_se0;
   logic        wake_k;

   // Bus phase registers
   logic        wr_pend_ff;
   logic        rd_pend_ff;
   logic [7:0]  addr_ff;
   logic [31:0] rdata_ff;
   logic        wr_phy;
   logic [31:0] nxt_rdata;
   logic        addr_phase;

   // Line state and suspend request pins pass two flip-flops before use
   always_ff @(posedge mclk) begin
      if (srst) begin
         ls_meta_ff   <= 2'(USBPS_LS_J);
         ls_sync_ff   <= 2'(USBPS_LS_J);
         susp_meta_ff <= 1'b0;
         susp_sync_ff <= 1'b0;
      end else begin
         ls_meta_ff   <= phy_linestate;
         ls_sync_ff   <= ls_meta_ff;
         susp_meta_ff <= suspend_req;
         susp_sync_ff <= susp_meta_ff;
      end
   end

   assign fif.raw        = ls_sync_ff;
   assign fif.log2_delay = filt_ff;

   usbps_linefilt u_filt (
      .mclk (mclk),
      .srst (srst),
      .fif  (fif)
   );

   // Packet capture
   always_ff @(posedge mclk) begin
      if (srst) begin
         pid_ff      <= 4'h0;
         ep_ff       <= 4'h0;
         ep_valid_ff <= 1'b0;
      end else if (rx_pkt_valid) begin
         pid_ff      <= rx_pid;
         ep_valid_ff <= rx_ep_valid;
         if (rx_ep_valid) begin
            ep_ff <= rx_ep;
         end
      end
   end

   // Receive port: tag endpoints marked in the mask
   always_ff @(posedge mclk) begin
      if (srst) begin
         rx_port_ep    <= 5'h00;
         rx_port_valid <= 1'b0;
      end else begin
         rx_port_valid <= rx_pkt_valid & rx_ep_valid;
         if (rx_pkt_valid & rx_ep_valid) begin
            rx_port_ep <= {ep_mask_ff[rx_ep], rx_ep};
         end
      end
   end

   // Suspend controller: line wake only when selected, else back to run when the request drops
   assign wake_se0 = fif.changed && fif.filt == 2'(USBPS_LS_SE0);
   assign wake_k   = fif.changed && fif.filt == 2'(USBPS_LS_K);

   always_ff @(posedge mclk) begin
      if (srst) begin
         st_ff <= USBPS_ST_RUN;
      end else begin
         unique case (st_ff)
            USBPS_ST_RUN: begin
               if (susp_sync_ff) begin
                  st_ff <= USBPS_ST_SUSP;
               end
            end
            USBPS_ST_SUSP: begin
               if (susp_sel_ff && (wake_se0 || wake_k)) begin
                  st_ff <= USBPS_ST_WAKE;
               end else if (!susp_sel_ff && !susp_sync_ff) begin
                  st_ff <= USBPS_ST_RUN;
               end
            end
            USBPS_ST_WAKE: begin
               if (!susp_sync_ff) begin
                  st_ff <= USBPS_ST_RUN;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         phy_suspend_n <= 1'b1;
      end else begin
         phy_suspend_n <= (st_ff != USBPS_ST_SUSP);
      end
   end

   // Bus slave: always ready, one wait-free data phase
   assign addr_phase = hsel & hready & htrans[1];

   always_ff @(posedge mclk) begin
      if (srst) begin
         wr_pend_ff <= 1'b0;
         rd_pend_ff <= 1'b0;
         addr_ff    <= 8'h00;
      end else if (hready) begin
         wr_pend_ff <= addr_phase & hwrite;
         rd_pend_ff <= addr_phase & ~hwrite;
         addr_ff    <= haddr[7:0];
      end
   end

   assign wr_phy = wr_pend_ff && addr_ff == `USBPS_PHY_CTRL_OFS;

   always_ff @(posedge mclk) begin
      if (srst) begin
         ep_mask_ff  <= 16'h0000;
         otg_mask_ff <= `USBPS_RESET_VAL;
         pwr_sig_ff  <= 9'h000;
         irq_en_ff   <= '0;
      end else if (wr_pend_ff) begin
         unique case (addr_ff)
            `USBPS_EP_MASK_OFS: ep_mask_ff  <= hwdata[15:0];
            `USBPS_OTG_MASK_OFS: otg_mask_ff <= hwdata;
            `USBPS_PWR_SIG_OFS: pwr_sig_ff  <= hwdata[8:0];
            `USBPS_IRQ_EN_OFS: irq_en_ff   <= hwdata[`USBPS_IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         pd_dis_ff   <= 1'b0;
         filt_ff     <= 4'h0;
         susp_sel_ff <= 1'b0;
         conf_ff     <= 3'h0;
      end else if (wr_phy) begin
         pd_dis_ff   <= hwdata[`USBPS_PULLDOWN_BIT];
         filt_ff     <= hwdata[`USBPS_FILT_LSB +: 4];
         susp_sel_ff <= hwdata[`USBPS_SUSP_SEL_BIT];
         conf_ff     <= hwdata[`USBPS_CONF_LSB +: 3];
      end
   end

   // Wake cause flags: hardware set wins over software clear
   always_ff @(posedge mclk) begin
      if (srst) begin
         se0_wake_ff <= 1'b0;
         k_wake_ff   <= 1'b0;
      end else begin
         if (st_ff == USBPS_ST_SUSP && susp_sel_ff && wake_se0) begin
            se0_wake_ff <= 1'b1;
         end else if (wr_phy && !hwdata[`USBPS_SE0_WAKE_BIT]) begin
            se0_wake_ff <= 1'b0;
         end
         if (st_ff == USBPS_ST_SUSP && susp_sel_ff && wake_k) begin
            k_wake_ff <= 1'b1;
         end else if (wr_phy && !hwdata[`USBPS_K_WAKE_BIT]) begin
            k_wake_ff <= 1'b0;
         end
      end
   end

   // PHY pins registered from their control bits, pulldown enables from the inverted disable bit
   always_ff @(posedge mclk) begin
      if (srst) begin
         pulldown_port_a_en <= 1'b1;
         pulldown_port_b_en <= 1'b1;
         phy_config_pins    <= 3'h0;
      end else begin
         pulldown_port_a_en <= ~pd_dis_ff;
         pulldown_port_b_en <= ~pd_dis_ff;
         phy_config_pins    <= conf_ff;
      end
   end

   // Interrupt status, set wins over clear
   always_comb begin
      irq_evt = '0;
      irq_evt[`USBPS_IRQ_PKT_BIT]  = rx_pkt_valid;
      irq_evt[`USBPS_IRQ_WAKE_BIT] = (st_ff == USBPS_ST_SUSP) &&
                                     susp_sel_ff && (wake_se0 || wake_k);
      irq_evt[`USBPS_IRQ_LINE_BIT] = fif.changed;
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         irq_stat_ff <= '0;
      end else if (wr_pend_ff && addr_ff == `USBPS_IRQ_CLR_OFS) begin
         irq_stat_ff <= (irq_stat_ff & ~hwdata[`USBPS_IRQ_W-1:0]) | irq_evt;
      end else begin
         irq_stat_ff <= irq_stat_ff | irq_evt;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_ff & irq_en_ff);
      end
   end

   // Read mux, registered at the address phase
   always_comb begin
      nxt_rdata = 32'h0000_0000;
      unique case (haddr[7:0])
         `USBPS_LAST_PID_OFS: nxt_rdata[3:0] = pid_ff;
         `USBPS_LAST_EP_OFS: nxt_rdata[4:0] = {ep_valid_ff, ep_ff};
         `USBPS_EP_MASK_OFS: nxt_rdata[15:0] = ep_mask_ff;
         `USBPS_OTG_MASK_OFS: nxt_rdata = otg_mask_ff;
         `USBPS_PWR_SIG_OFS: nxt_rdata[8:0] = pwr_sig_ff;
         `USBPS_PHY_CTRL_OFS: begin
            nxt_rdata[`USBPS_PULLDOWN_BIT]   = pd_dis_ff;
            nxt_rdata[`USBPS_SE0_WAKE_BIT]   = se0_wake_ff;
            nxt_rdata[`USBPS_K_WAKE_BIT]     = k_wake_ff;
            nxt_rdata[`USBPS_FILT_LSB +: 4]  = filt_ff;
            nxt_rdata[`USBPS_SUSP_SEL_BIT]   = susp_sel_ff;
            nxt_rdata[`USBPS_CONF_LSB +: 3]  = conf_ff;
         end
         `USBPS_IRQ_STAT_OFS: nxt_rdata[`USBPS_IRQ_W-1:0] = irq_stat_ff;
         `USBPS_IRQ_EN_OFS: nxt_rdata[`USBPS_IRQ_W-1:0] = irq_en_ff;
         `USBPS_LINE_STAT_OFS: nxt_rdata[1:0] = fif.filt;
         default: nxt_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (addr_phase & ~hwrite) begin
         rdata_ff <= nxt_rdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (srst) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   assign hrdata = rdata_ff;

   if (FILT_MAX != 4'hf) begin : g_filt_chk
      $error("filter width mismatch");
   end
endmodule : usbps_top
`default_nettype wire

// ==== dv/usbps_phy_model.sv ====
// Behavioural PHY: shows the commanded bus state on its line pins
`timescale 1ns/10ps
`default_nettype none
module usbps_phy_model (
   input  wire logic       mclk,      // Module clock
   input  wire logic [1:0] line_cmd,  // Bus state to present
   input  wire logic       suspend_n, // Low while suspended
   output logic      [1:0] linestate  // Line state pins
);
   // Still reports the line when suspended, else no wake could be seen
   always_ff @(posedge mclk) begin
      linestate <= line_cmd;
   end
endmodule : usbps_phy_model
`default_nettype wire

// ==== dv/usbps_properties.sv ====
// Port checks for the packet snoop and PHY control block
`timescale 1ns/10ps
`default_nettype none
module usbps_properties (
   input wire logic        mclk,               // Clock
   input wire logic        srst,               // Reset
   input wire logic        hsel,               // Select
   input wire logic [31:0] haddr,              // Address
   input wire logic [1:0]  htrans,             // Transfer type
   input wire logic        hwrite,             // Write
   input wire logic [31:0] hwdata,             // Write data
   input wire logic        hready,             // Bus ready
   input wire logic        hreadyout,          // Slave ready
   input wire logic        rx_pkt_valid,       // Packet strobe
   input wire logic        rx_ep_valid,        // Endpoint valid
   input wire logic [3:0]  rx_ep,              // Endpoint
   input wire logic [4:0]  rx_port_ep,         // Port endpoint
   input wire logic        rx_port_valid,      // Port strobe
   input wire logic        pulldown_port_a_en, // Pulldown a
   input wire logic        pulldown_port_b_en, // Pulldown b
   input wire logic [2:0]  phy_config_pins     // Config pins
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   sequence s_ctrl_addr;
      hsel && hready && htrans[1] && hwrite && haddr == 32'h0000_0040;
   endsequence
   sequence s_ctrl_wr;
      s_ctrl_addr ##1 1'b1;
   endsequence
   sequence s_ep_pkt;
      rx_pkt_valid && rx_ep_valid;
   endsequence
   a_bus_ready: assert property (hreadyout)
      else $error("slave inserted a wait state");
   a_port_strobe: assert property (s_ep_pkt |=> rx_port_valid)
      else $error("receive port strobe missing");
   a_port_quiet: assert property (!(rx_pkt_valid && rx_ep_valid)
      |=> !rx_port_valid) else $error("receive port strobe unprompted");
   a_port_ep: assert property (s_ep_pkt
      |=> rx_port_ep[3:0] == $past(rx_ep))
      else $error("receive port endpoint wrong");
   a_port_hold: assert property (!(rx_pkt_valid && rx_ep_valid)
      |=> $stable(rx_port_ep)) else $error("receive port changed idle");
   a_pulldown_pair: assert property (
      pulldown_port_a_en == pulldown_port_b_en)
      else $error("pulldown enables differ");
   a_pulldown_write: assert property (s_ctrl_wr
      |=> ##1 pulldown_port_a_en == !$past(hwdata[18], 2))
      else $error("pulldown not set by write");
   a_config_write: assert property (s_ctrl_wr
      |=> ##1 phy_config_pins == $past(hwdata[6:4], 2))
      else $error("config pins not set by write");
   a_config_hold: assert property (!(hsel && hready && htrans[1]
      && hwrite && haddr == 32'h0000_0040) |-> ##3 $stable(phy_config_pins))
      else $error("config pins changed without write");
endmodule : usbps_properties
bind usbps_top usbps_properties u_props (.mclk, .srst, .hsel, .haddr,
   .htrans, .hwrite, .hwdata, .hready, .hreadyout, .rx_pkt_valid,
   .rx_ep_valid, .rx_ep, .rx_port_ep, .rx_port_valid, .pulldown_port_a_en,
   .pulldown_port_b_en, .phy_config_pins);
`default_nettype wire

// ==== dv/tb_usbps_top.sv ====
// Register-level bench for the packet snoop and PHY control block
`timescale 1ns/10ps
`default_nettype none
module tb_usbps_top;
   logic        mclk, srst, hsel, hwrite, hready, hreadyout, hresp;
   logic        rx_pkt_valid, rx_ep_valid, rx_port_valid, suspend_req;
   logic        pd_a, pd_b, phy_suspend_n, irq;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans, line_cmd, phy_linestate;
   logic [2:0]  hsize, cfg;
   logic [3:0]  rx_pid, rx_ep;
   logic [4:0]  rx_port_ep;
   int          mismatches, num_checks;
   assign hready = hreadyout;
   usbps_top dut (.mclk, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rx_pkt_valid,
      .rx_pid, .rx_ep_valid, .rx_ep, .rx_port_ep, .rx_port_valid,
      .phy_linestate, .suspend_req, .pulldown_port_a_en(pd_a),
      .pulldown_port_b_en(pd_b), .phy_config_pins(cfg), .phy_suspend_n,
      .irq);
   usbps_phy_model phy (.mclk, .line_cmd, .suspend_n(phy_suspend_n),
      .linestate(phy_linestate));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
      end
   endtask : check
   task automatic summarize;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : summarize
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask : cyc
   // Address phase held until ready, then data phase until ready
   task automatic bus(input logic [31:0] a, input logic w,
                      input logic [31:0] d);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      do @(posedge mclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk); while (hready !== 1'b1);
   endtask : bus
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask : wr
   task automatic rd(input logic [31:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffff_ffff);
      bus(a, 1'b0, 32'h0000_0000);
      check(hrdata & m, e);
      check({31'h0, hresp}, 32'h0);
   endtask : rd
   task automatic pkt(input logic [3:0] p, input logic [3:0] e,
                      input logic v, input logic [4:0] pe);
      rx_pkt_valid <= 1'b1;
      rx_pid <= p;
      rx_ep <= e;
      rx_ep_valid <= v;
      @(posedge mclk);
      rx_pkt_valid <= 1'b0;
      @(posedge mclk);
      check({27'h0, rx_port_ep}, {27'h0, pe});
   endtask : pkt
   task automatic line(input logic [1:0] s, input int n);
      line_cmd <= s;
      cyc(n);
   endtask : line
   initial begin
      srst = 1'b1;
      {hsel, hwrite, rx_pkt_valid, rx_ep_valid, suspend_req} = '0;
      {haddr, hwdata, htrans, rx_pid, rx_ep} = '0;
      hsize = 3'h2;
      line_cmd = 2'h1;
      cyc(12);
      srst <= 1'b0;
      cyc(1);
      for (int a = 'h2c; a <= 'h4c; a += 4) begin
         rd(a, 32'h0000_0000);
      end
      rd(32'h0000_0080, 32'h0000_0000);
      check({31'h0, pd_a & pd_b}, 32'h1);
      check({29'h0, cfg}, 32'h0);
      wr(32'h0000_002c, 32'hffff_ffff);
      wr(32'h0000_0034, 32'hffff_0020);
      rd(32'h0000_0034, 32'h0000_0020);
      wr(32'h0000_0038, 32'ha5a5_5a5a);
      rd(32'h0000_0038, 32'ha5a5_5a5a);
      wr(32'h0000_003c, 32'hffff_ffff);
      rd(32'h0000_003c, 32'h0000_01ff);
      pkt(4'hd, 4'h5, 1'b1, 5'h15);
      pkt(4'h3, 4'h9, 1'b1, 5'h09);
      rd(32'h0000_002c, 32'h0000_0003);
      rd(32'h0000_0030, 32'h0000_0019);
      pkt(4'ha, 4'h7, 1'b0, 5'h09);
      rd(32'h0000_002c, 32'h0000_000a);
      rd(32'h0000_0030, 32'h0000_0009);
      wr(32'h0000_0040, 32'hffff_ffff);
      rd(32'h0000_0040, 32'h0004_0ff0);
      check({30'h0, pd_a, pd_b}, 32'h0);
      check({29'h0, cfg}, 32'h7);
      // Filter of 16 cycles: a wrong decode would already pass at 10
      wr(32'h0000_0040, 32'h0000_0400);
      line(2'h2, 10);
      rd(32'h0000_0050, 32'h0000_0001);
      cyc(20);
      rd(32'h0000_0050, 32'h0000_0002);
      check({31'h0, irq}, 32'h0);
      wr(32'h0000_0040, 32'h0000_0000);
      line(2'h1, 8);
      suspend_req <= 1'b1;
      line(2'h2, 10);
      check({31'h0, phy_suspend_n}, 32'h0);
      rd(32'h0000_0040, 32'h0000_0000);
      suspend_req <= 1'b0;
      line(2'h1, 8);
      check({31'h0, phy_suspend_n}, 32'h1);
      wr(32'h0000_0040, 32'h0000_0080);
      wr(32'h0000_004c, 32'h0000_0002);
      suspend_req <= 1'b1;
      cyc(8);
      line(2'h2, 10);
      suspend_req <= 1'b0;
      rd(32'h0000_0040, 32'h0000_1080);
      rd(32'h0000_0044, 32'h0000_0002, 32'h0000_0002);
      check({31'h0, irq}, 32'h1);
      wr(32'h0000_0048, 32'h0000_0002);
      cyc(2);
      check({31'h0, irq}, 32'h0);
      wr(32'h0000_0040, 32'h0000_0080);
      rd(32'h0000_0040, 32'h0000_0080);
      line(2'h1, 8);
      suspend_req <= 1'b1;
      cyc(8);
      line(2'h0, 10);
      suspend_req <= 1'b0;
      wr(32'h0000_0040, 32'h0000_2080);
      rd(32'h0000_0040, 32'h0000_2080);
      wr(32'h0000_0040, 32'h0000_0080);
      rd(32'h0000_0040, 32'h0000_0080);
      check({31'h0, irq}, 32'h1);
      wr(32'h0000_004c, 32'h0000_0000);
      cyc(2);
      check({31'h0, irq}, 32'h0);
      summarize();
   end
   initial begin
      cyc(5000);
      mismatches++;
      summarize();
   end
endmodule : tb_usbps_top
`default_nettype wire
